/* File: hdl/emrom_top.sv */
/*
 Emulation ROM decoder: static RAM standing in for target program ROM.
 Assumes target bus inputs synchronous to clk, and a host-side load port.
*/
//
// Function
// [RL1] Enabled block read drives addressed data
// [RL2] Target writes never change the memory
// [RL3] Decoder takes full 20-bit address
// [RL4] Independent enable per 2K block
// [RL5] All enabled blocks share one 128K region
// [RL6] Upper three address bits must match segment
// [RL7] Base build: four addresses per location
// [RL8] Base build ignores address bits 15, 16
// [RL9] Expansion gives every address own location
// [RL10] Segment value supplies address bits 16-19
// [RL11] Clear disables all block enables
// [RL12] Additive update keeps existing enables
// [RL13] Segment and enable map readable
// [RL14] Target may drive top address bit
// [RL15] Target sockets empty during emulation
// [RL16] Decoder sees every target address line
// [RL17] Sample setup enables block, sets segment
// [RL18] Segment compare before block lookup
// [RL19] Ordinary setting replaces the enable map
// [RL20] Data outputs idle outside matching reads
`timescale 1ns/1ns
`default_nettype none
`include "emrom_map.svh"
module emrom_top #(
    parameter bit EXPANDED = 1'b0
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // Target bus
    input  wire emrom_pkg::emrom_addr_t tgt_addr,
    input  wire logic                   tgt_rd,
    input  wire logic                   tgt_wr,
    output logic [`EMROM_DATA_W-1:0]    tgt_data_o,
    output logic                        tgt_data_oe,
    // Host block enable control
    input  wire logic                   block_enable_command,
    input  wire logic                   enable_also,
    input  wire emrom_pkg::emrom_blk_t  enable_first_blk,
    input  wire emrom_pkg::emrom_blk_t  enable_last_blk,
    input  wire logic                   segment_write,
    input  wire emrom_pkg::emrom_seg_t  segment_select_value,
    input  wire logic                   clear_all_enables,
    input  wire logic                   load_sample_program,
    // Host memory load
    input  wire logic                   host_wr,
    input  wire logic [16:0]            host_addr,
    input  wire emrom_pkg::emrom_data_t host_wdata,
    // Status
    output emrom_pkg::emrom_seg_t       enable_status_seg,
    output emrom_pkg::emrom_map_t       enable_status_report,
    output logic                        sample_busy
);
    import emrom_pkg::*;

    // ==========================================================
    // Reset synchroniser
    logic rst_s1_q, rst_s2_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    logic srst_n;
    assign srst_n = rst_s2_q;

    // ==========================================================
    // Sample program loader
    localparam int SLEN = `EMROM_SAMPLE_LEN;
    // Small loop program: jump to itself
    function automatic emrom_data_t sample_byte(input logic [1:0] i);
        unique case (i)
            2'd0: sample_byte = 8'hC3;
            2'd1: sample_byte = 8'h00;
            2'd2: sample_byte = 8'h00;
            2'd3: sample_byte = 8'h00;
        endcase
    endfunction : sample_byte

    emrom_ld_e  ld_q;
    logic [1:0] ld_cnt_q;
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            ld_q     <= EMROM_IDLE;
            ld_cnt_q <= 2'd0;
        end else begin
            unique case (ld_q)
                EMROM_IDLE: if (load_sample_program) begin
                    ld_q     <= EMROM_SAMPLE;
                    ld_cnt_q <= 2'd0;
                end
                EMROM_SAMPLE: begin
                    ld_cnt_q <= ld_cnt_q + 2'd1;
                    if (ld_cnt_q == 2'(SLEN - 1)) ld_q <= EMROM_DONE;
                end
                EMROM_DONE: ld_q <= EMROM_IDLE;
                default: ld_q <= EMROM_IDLE;
            endcase
        end
    end
    assign sample_busy = (ld_q != EMROM_IDLE);

    // ==========================================================
    // Segment and enable map
    emrom_seg_t seg_q;
    emrom_map_t map_q;
    emrom_map_t range_mask;
    always_comb begin
        range_mask = '0;
        // A range names blocks of one 64K half; higher indices would spill into the other half
        for (int i = 0; i < `EMROM_NBLK / 2; i++) begin
            if (6'(i) >= enable_first_blk && 6'(i) <= enable_last_blk) range_mask[i] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            seg_q <= `EMROM_SEG_RST;
        end else if (ld_q == EMROM_IDLE && load_sample_program) begin
            seg_q <= `EMROM_SAMPLE_SEG;                                         // [RL17]
        end else if (segment_write) begin
            seg_q <= segment_select_value;                                      // [RL10]
        end
    end

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            map_q <= '0;
        end else if (clear_all_enables) begin
            map_q <= '0;                                                        // [RL11]
        end else if (ld_q == EMROM_IDLE && load_sample_program) begin
            map_q <= '0;
            map_q[`EMROM_SAMPLE_BLK] <= 1'b1;                                   // [RL17]
        end else if (block_enable_command) begin
            // Enables in the 64K half chosen by segment bit 0
            if (enable_also) map_q <= map_q | (range_mask << (seg_q[0] ? 32 : 0)); // [RL12]
            else             map_q <= range_mask << (seg_q[0] ? 32 : 0);       // [RL19] [RL4]
        end
    end
    assign enable_status_seg    = seg_q;                                        // [RL13]
    assign enable_status_report = map_q;                                        // [RL13]

    // ==========================================================
    // Emulation RAM
    logic hit;
    emrom_decode u_dec (
        .addr    (tgt_addr),                                                    // [RL3] [RL16]
        .seg     (seg_q),
        .blk_map (map_q),
        .hit     (hit)
    );

    // Base build folds bits 15 and 16 away, so four addresses share a byte
    function automatic logic [16:0] ram_index(input logic [16:0] a);
        ram_index = EXPANDED ? a : {2'b00, a[14:0]};                            // [RL7] [RL8] [RL9]
    endfunction : ram_index

    emrom_data_t mem [0:(1<<`EMROM_EXP_AW)-1];
    logic [16:0] ld_addr;
    assign ld_addr = {`EMROM_SAMPLE_BLK, 11'h000} + {15'h0000, ld_cnt_q};
    // Only the host port and the sample loader write; target write strobes are not connected here
    always_ff @(posedge clk) begin
        if (ld_q == EMROM_SAMPLE) mem[ram_index(ld_addr)] <= sample_byte(ld_cnt_q);
        else if (host_wr)         mem[ram_index(host_addr)] <= host_wdata;      // [RL2]
    end

    // ==========================================================
    // Target read response
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            tgt_data_o  <= '0;
            tgt_data_oe <= 1'b0;
        end else begin
            tgt_data_oe <= tgt_rd && !tgt_wr && hit;                            // [RL20] [RL2]
            tgt_data_o  <= mem[ram_index(tgt_addr[16:0])];                      // [RL1]
        end
    end

    // ==========================================================
    // Checks
    logic past_ok;
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) past_ok <= 1'b0;
        else         past_ok <= 1'b1;
    end

    read_drive_a: assert property (@(posedge clk) disable iff (!srst_n)       // [RL1]
        past_ok && $past(tgt_rd && !tgt_wr && hit) |-> tgt_data_oe)
        else $error("enabled read not driven");
    idle_bus_a: assert property (@(posedge clk) disable iff (!srst_n)         // [RL20]
        past_ok && !$past(tgt_rd && hit) |-> !tgt_data_oe)
        else $error("data driven outside matching read");
    write_nodrive_a: assert property (@(posedge clk) disable iff (!srst_n)    // [RL2]
        past_ok && $past(tgt_wr) |-> !tgt_data_oe)
        else $error("data driven during target write");
    seg_match_a: assert property (@(posedge clk) disable iff (!srst_n)        // [RL6]
        tgt_data_oe |-> $past(tgt_addr[19:17]) == $past(seg_q[3:1]))
        else $error("answer outside segment region");
    clear_map_a: assert property (@(posedge clk) disable iff (!srst_n)        // [RL11]
        clear_all_enables |=> map_q == '0)
        else $error("clear left an enable set");
    also_keep_a: assert property (@(posedge clk) disable iff (!srst_n)        // [RL12]
        block_enable_command && enable_also && !clear_all_enables && !load_sample_program
        |=> (map_q & $past(map_q)) == $past(map_q))
        else $error("additive update lost an enable");
    replace_map_a: assert property (@(posedge clk) disable iff (!srst_n)      // [RL19]
        block_enable_command && !enable_also && !clear_all_enables && !load_sample_program
        && enable_first_blk > 6'd0 |=> !map_q[0] && !map_q[32])
        else $error("ordinary setting kept old enables");
    sample_setup_a: assert property (@(posedge clk) disable iff (!srst_n)      // [RL17]
        ld_q == EMROM_IDLE && load_sample_program && !clear_all_enables
        |=> map_q[0] && seg_q == `EMROM_SAMPLE_SEG ##[4:4] ld_q == EMROM_DONE)
        else $error("sample setup incomplete");
    status_seg_a: assert property (@(posedge clk) disable iff (!srst_n)       // [RL13]
        segment_write && !load_sample_program |=> enable_status_seg == $past(segment_select_value))
        else $error("segment status not reported");

    read_hit_c:   cover property (@(posedge clk) disable iff (!srst_n) tgt_data_oe);
    also_c:       cover property (@(posedge clk) disable iff (!srst_n) block_enable_command && enable_also);
    sample_c:     cover property (@(posedge clk) disable iff (!srst_n) ld_q == EMROM_DONE);
    seg_miss_c:   cover property (@(posedge clk) disable iff (!srst_n) tgt_rd && !hit && map_q != '0);
endmodule : emrom_top
`default_nettype wire

/* File: hdl/emrom_map.svh */
/*
 Constants for the emulation ROM decoder: address split, block map size,
 segment reset value and sample program setup.
 Assumes inclusion by name from the design files.
*/
`ifndef EMROM_MAP_SVH
`define EMROM_MAP_SVH
`define EMROM_ADDR_W      20
`define EMROM_DATA_W      8
`define EMROM_SEG_W       4
`define EMROM_BLK_W       5
`define EMROM_NBLK        64
`define EMROM_BLK_LSB     11
`define EMROM_BASE_AW     15
`define EMROM_EXP_AW      17
`define EMROM_SEG_RST     4'hF
`define EMROM_SAMPLE_SEG  4'h0
`define EMROM_SAMPLE_BLK  6'h00
`define EMROM_SAMPLE_LEN  4
`endif

/* File: hdl/emrom_pkg.sv */
/*
 Types for the emulation ROM decoder.
 Assumes emrom_map.svh is on the include path.
*/
`include "emrom_map.svh"
package emrom_pkg;
    typedef logic [`EMROM_ADDR_W-1:0] emrom_addr_t;
    typedef logic [`EMROM_DATA_W-1:0] emrom_data_t;
    typedef logic [`EMROM_SEG_W-1:0]  emrom_seg_t;
    typedef logic [`EMROM_NBLK-1:0]   emrom_map_t;
    typedef logic [5:0]               emrom_blk_t;
    typedef enum logic [1:0] {
        EMROM_IDLE   = 2'b00,
        EMROM_SAMPLE = 2'b01,
        EMROM_DONE   = 2'b10
    } emrom_ld_e;
endpackage : emrom_pkg

/* File: hdl/emrom_decode.sv */
/*
 Address match for the emulation ROM: segment compare, then block enable lookup.
 Assumes a synchronous target address already stable in the sampling cycle.
*/
`timescale 1ns/1ns
`default_nettype none
`include "emrom_map.svh"
module emrom_decode (
    // Target address and settings
    input  wire emrom_pkg::emrom_addr_t addr,
    input  wire emrom_pkg::emrom_seg_t  seg,
    input  wire emrom_pkg::emrom_map_t  blk_map,
    // Result
    output logic                        hit
);
    import emrom_pkg::*;
    logic seg_ok;
    logic [5:0] blk_idx;
    // Top three bits choose the 128K region, A16 selects the 64K half
    assign seg_ok  = (addr[19:17] == seg[3:1]);                                 // [RL6] [RL5] [RL10]
    assign blk_idx = {addr[16], addr[15:`EMROM_BLK_LSB]};                       // [RL4]
    // Block lookup only counts once the segment has matched
    assign hit     = seg_ok && blk_map[blk_idx];                                // [RL18]
endmodule : emrom_decode
`default_nettype wire

/* File: testbench/emrom_target_bus.sv */
/*
 Target data bus model: resolves the emulation data lines as the target sees them.
 Assumes the emulated sockets are empty, so no other device drives the bus.
*/
`timescale 1ns/1ns
`default_nettype none
module emrom_target_bus (
    // Emulation side
    input  wire logic       data_oe,
    input  wire logic [7:0] data_o,
    // Target view
    output logic [7:0]      bus
);
    // ============================================================
    // Bus resolution
    logic [7:0] last_q = 8'h00;
    // Only the emulator drives; a released bus shows the inverse of its last value
    always @* bus = data_oe ? data_o : ~last_q;
    always @(data_o or data_oe) if (data_oe) last_q = data_o;
endmodule : emrom_target_bus
`default_nettype wire

/* File: testbench/emulation_rom_decoder_tb.sv */
/*
 Self-checking bench for the emulation ROM decoder, base build.
 Assumes emrom_pkg and emrom_map.svh are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "emrom_map.svh"
module emulation_rom_decoder_tb;
    import emrom_pkg::*;
    // ============================================================
    // Stimulus and model state
    logic clk = 1'b0, rst_n = 1'b0, tgt_rd = 1'b0, tgt_wr = 1'b0, host_wr = 1'b0;
    logic block_enable_command = 1'b0, enable_also = 1'b0, segment_write = 1'b0;
    logic clear_all_enables = 1'b0, load_sample_program = 1'b0;
    emrom_addr_t tgt_addr = 20'h00000;
    emrom_blk_t  first_blk = 6'h00, last_blk = 6'h00;
    emrom_seg_t  seg_val = 4'h0, st_seg, m_seg = 4'hF;
    logic [16:0] host_addr = 17'h00000;
    emrom_data_t host_wdata = 8'h00;
    logic [7:0]  data_o, bus;
    logic        data_oe, sample_busy;
    emrom_map_t  st_map, m_map = '0;
    logic [7:0]  mem [0:32767];
    logic [14:0] wq[$];
    logic [31:0] rng = 32'd29420;
    int fail_count = 0, checks_done = 0, i;
    always #5 clk = ~clk;
    emrom_top #(.EXPANDED(1'b0)) dut (.clk(clk), .rst_n(rst_n), .tgt_addr(tgt_addr), .tgt_rd(tgt_rd),
        .tgt_wr(tgt_wr), .tgt_data_o(data_o), .tgt_data_oe(data_oe),
        .block_enable_command(block_enable_command), .enable_also(enable_also),
        .enable_first_blk(first_blk), .enable_last_blk(last_blk), .segment_write(segment_write),
        .segment_select_value(seg_val), .clear_all_enables(clear_all_enables),
        .load_sample_program(load_sample_program), .host_wr(host_wr), .host_addr(host_addr),
        .host_wdata(host_wdata), .enable_status_seg(st_seg), .enable_status_report(st_map),
        .sample_busy(sample_busy));
    emrom_target_bus tbus (.data_oe(data_oe), .data_o(data_o), .bus(bus));
    // ============================================================
    // Helpers
    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : rnd
    task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask : cmp
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick
    task automatic chk_stat();
        cmp("status_seg", {60'h0, m_seg}, {60'h0, st_seg});
        cmp("status_map", m_map, st_map);
    endtask : chk_stat
    task automatic rd(input logic [19:0] a, input logic wr);
        logic hit;
        tgt_addr = a;
        tgt_rd = 1'b1;
        tgt_wr = wr;
        tick();
        hit = !wr && a[19:17] === m_seg[3:1] && m_map[a[16:11]];
        cmp("read_oe", {63'h0, hit}, {63'h0, data_oe});
        if (hit) cmp("read_data", {56'h0, mem[a[14:0]]}, {56'h0, bus});
    endtask : rd
    task automatic seg(input logic [3:0] s);
        seg_val = s;
        segment_write = 1'b1;
        tick();
        segment_write = 1'b0;
        m_seg = s;
    endtask : seg
    task automatic enable(input logic [5:0] f, input logic [5:0] l, input logic also);
        int b;
        first_blk = f;
        last_blk = l;
        enable_also = also;
        block_enable_command = 1'b1;
        tick();
        block_enable_command = 1'b0;
        if (!also) m_map = '0;
        for (b = f; b <= l; b++) m_map[{m_seg[0], b[4:0]}] = 1'b1;
    endtask : enable
    task automatic conclude();
        if (fail_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    // ============================================================
    // Main sequence
    initial begin
        logic [3:0] tb [6];
        logic [14:0] w;
        tb = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9};
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (3) tick();
        chk_stat();
        rd(20'hF0000, 1'b0);
        load_sample_program = 1'b1;
        tick();
        load_sample_program = 1'b0;
        for (i = 0; i < 20 && sample_busy !== 1'b0; i++) tick();
        if (i == 20) begin
            fail_count++;
            conclude();
        end
        cmp("sample_cycles", 64'(`EMROM_SAMPLE_LEN + 1), 64'(i));
        m_seg = 4'h0;
        m_map = 64'h1;
        for (i = 0; i < 4; i++) begin
            mem[i] = (i == 0) ? 8'hC3 : 8'h00;
            wq.push_back(15'(i));
        end
        chk_stat();
        // Only the four loaded bytes are known; unwritten cells would compare unknown to unknown
        for (i = 0; i < 5; i++) rd(20'(i % 4), 1'b0);
        for (i = 0; i < 40; i++) begin
            w = {tb[rnd() % 6], 11'(rnd())};
            host_addr = {2'(rnd()), w};
            host_wdata = 8'(rnd());
            host_wr = 1'b1;
            mem[w] = host_wdata;
            wq.push_back(w);
            tick();
        end
        host_wr = 1'b0;
        seg(4'h4);
        enable(6'h00, 6'h03, 1'b0);
        seg(4'h5);
        enable(6'h08, 6'h09, 1'b1);
        tick();
        chk_stat();
        for (i = 0; i < 300; i++) begin
            w = wq[rnd() % wq.size()];
            // All 20 lines driven, top bit freely as chip-select logic would
            rd({(rnd() % 5 == 0) ? 3'(rnd()) : m_seg[3:1], 2'(rnd()), w}, rnd() % 8 == 0);
        end
        tgt_rd = 1'b0;
        tick();
        cmp("idle_oe", 64'h0, {63'h0, data_oe});
        enable(6'h02, 6'h05, 1'b0);
        chk_stat();
        rd({m_seg[3:1], 17'h00000}, 1'b0);
        clear_all_enables = 1'b1;
        tick();
        clear_all_enables = 1'b0;
        m_map = '0;
        tick();
        chk_stat();
        rd({m_seg[3:1], 17'h00000}, 1'b0);
        conclude();
    end
endmodule : emulation_rom_decoder_tb
`default_nettype wire
